// file: logic/stotr_translator.sv
// Functional notes
// - Clear the starting synchronizer's output buffer at write start
// - Clear flag sets at start slot, ends at strobe
// - Clear pulses from ring phases 4,5,0,1,3
// - At most one clear flag set
// - Seven-bit character: value, zone, check
// - Accept one-digit and two-digit codes
// - Inputs use standard digit code
// - One shared translator, non-overlapping cycles
// - Check error writes all ones at T0 after the character
// - Numeric mode reads digit at T4
// - Alpha mode reads low T4, high T6
// - All buffer halves ORed into high register
// - High register changes only at even slots
// - Digit staged high then low stage
// - Translate at T7 with both digits, or the low one in numeric mode
// - Single-digit flag set T5, reset T7
// - Low digit decoded onto eight lines
// - Symbol lines only in single-digit mode
// - Range lines from high digit pair
// - One-digit range lines from fourth bit
// - Encoder gives six bits and check terms
// - Checker compares outputs with inverse
// - Check at T7, errors raised at T0
// - Write cycle lasts 4 us, one at once
`timescale 1ns/1ns
`include "stotr_defines.svh"

module stotr_translator #(
	parameter int NSYNC = 4,                      // Synchronizers sharing the translator
	parameter int WCYC_CYC = `STOTR_WCYC_CYC      // Write cycle length in clocks
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic [7:0] slot_pulse,
	input wire logic [5:0] ring_phase_pulse,
	input wire logic clear_start_slot,
	input wire logic fast_density_toggle,
	input wire logic [NSYNC-1:0] write_slot_strobe,
	input wire logic [NSYNC-1:0][1:0][4:0] buf_digit,
	output logic [NSYNC-1:0] buf_read_lo,
	output logic [NSYNC-1:0] buf_read_hi,
	output logic [NSYNC-1:0] buf_clear,
	output logic [6:0] tape_char,
	output logic tape_char_strobe,
	output logic [NSYNC-1:0] tape_sync_sel,
	output logic output_check_diag_error,
	output logic output_check_sync_error,
	output logic [NSYNC-1:0] sync_master_error_set
);

	localparam logic [9:0] WCYC_LAST = 10'(WCYC_CYC - 1); // Last count of a write cycle

	// Whole state of the block
	typedef struct packed {
		stotr_pkg::stotr_wstate_type [NSYNC-1:0] wstate; // Write operation progress
		logic [NSYNC-1:0] alpha;        // Two-digit mode per synchronizer
		logic [NSYNC-1:0] clr_flag;     // Buffer-clear flags
		logic [NSYNC-1:0] wcyc;         // Write-cycle flags
		logic [9:0] wcnt;               // Write cycle length counter
		logic [NSYNC-1:0] half;         // Next buffer half in numeric mode
		logic [4:0] high_digit;         // Shared high-digit register
		logic [4:0] low_digit;          // Low-digit stage
		logic single;                   // Single-digit-translate flag
		logic err_pend;                 // Mismatch seen at T7
		logic [NSYNC-1:0] err_sync;     // Owner of the pending mismatch
		logic [6:0] char_out;           // Write-output flops
		logic char_strobe;              // Character ready pulse
		logic [NSYNC-1:0] sync_sel;     // Owner of the character
		logic diag_err;                 // Diagnostic error pulse
		logic sync_err;                 // Synchronizer error pulse
		logic [NSYNC-1:0] merr_set;     // Master error set pulses
		logic [NSYNC-1:0] merr;         // Sticky master error flags
		logic [31:0] rdata;             // Read data
	} stotr_state_type;

	stotr_state_type st_r;
	stotr_state_type st_nxt;

	stotr_pkg::stotr_lines_type lines;   // Decoder outputs
	stotr_pkg::stotr_enc_type enc;       // Encoder outputs
	stotr_pkg::stotr_enc_type enc_inv;   // Independent inverse
	logic [4:0] merged_digit;            // ORed buffer outputs
	logic [NSYNC-1:0][4:0] sync_digit;   // Per-synchronizer gated digit
	logic clear_phase;                   // Ring phases that clear digits
	logic check_bad;                     // Output disagrees with inverse
	logic [6:0] xlate_char;              // Assembled seven-bit character

	// Ring phases driving buffer clearing; phase 2 is not used
	assign clear_phase = ring_phase_pulse[4] | ring_phase_pulse[5] | ring_phase_pulse[0] |
		ring_phase_pulse[1] | ring_phase_pulse[3];

	// Per-synchronizer buffer strobes and gating onto the shared bus
	genvar g;
	generate
		for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
			// Numeric mode alternates halves; alpha mode reads low then high
			assign buf_read_lo[g] = st_r.wcyc[g] && ((slot_pulse[4] &&
				(st_r.alpha[g] || !st_r.half[g])));
			assign buf_read_hi[g] = st_r.wcyc[g] && ((slot_pulse[4] && !st_r.alpha[g] &&
				st_r.half[g]) || (slot_pulse[6] && st_r.alpha[g]));
			assign buf_clear[g] = st_r.clr_flag[g] && clear_phase;
			assign sync_digit[g] = (buf_read_lo[g] ? buf_digit[g][0] : 5'h00) |
				(buf_read_hi[g] ? buf_digit[g][1] : 5'h00);
		end
	endgenerate

	// Only one synchronizer reads at a time, so an OR is a safe merge
	always_comb begin
		merged_digit = 5'h00;
		for (int i = 0; i < NSYNC; i++) begin
			merged_digit = merged_digit | sync_digit[i];
		end
	end

	// Digits are standard code, no memory-code conversion
	stotr_decoder u_dec (
		.low_digit(st_r.low_digit),
		.high_digit(st_r.high_digit),
		.single_digit(st_r.single),
		.lines(lines)
	);

	stotr_encoder u_enc (
		.lines(lines),
		.enc(enc),
		.enc_inv(enc_inv)
	);

	// Check bit is set when both terms of either pair are set
	assign xlate_char = {(enc.check_term[0] & enc.check_term[1]) |
		(enc.check_term[2] & enc.check_term[3]), enc.bits};
	// Any bit equal to its own inverse is an error
	assign check_bad = |(~({enc.bits, enc.check_term} ^ {enc_inv.bits, enc_inv.check_term}));

	// Next state
	always_comb begin
		logic any_clr;
		logic any_wcyc;
		logic clr_granted;
		logic [NSYNC-1:0] merr_clear;
		any_clr = |st_r.clr_flag;
		any_wcyc = |st_r.wcyc;
		clr_granted = 1'b0;
		merr_clear = '0;
		st_nxt = st_r;

		// Pulses last one cycle
		st_nxt.char_strobe = 1'b0;
		st_nxt.diag_err = 1'b0;
		st_nxt.sync_err = 1'b0;
		st_nxt.merr_set = '0;
		st_nxt.rdata = 32'h0000_0000;

		// Register writes
		if (reg_wr && reg_addr == `STOTR_OFS_CTRL) begin
			st_nxt.alpha = reg_wdata[`STOTR_CTRL_ALPHA_LSB +: NSYNC];
		end
		if (reg_wr && reg_addr == `STOTR_OFS_ERRCLR) begin
			merr_clear = reg_wdata[`STOTR_STAT_MERR_LSB +: NSYNC];
		end

		// Per-synchronizer operation control
		for (int i = 0; i < NSYNC; i++) begin
			case (st_r.wstate[i])
				stotr_pkg::STOTR_IDLE: begin
					// A start always goes through a clear cycle first
					if (reg_wr && reg_addr == `STOTR_OFS_CTRL &&
						reg_wdata[`STOTR_CTRL_START_LSB + i]) begin
						st_nxt.wstate[i] = stotr_pkg::STOTR_CLEARING;
					end
				end
				stotr_pkg::STOTR_CLEARING: begin
					if (st_r.clr_flag[i] && write_slot_strobe[i]) begin
						st_nxt.clr_flag[i] = 1'b0;
						st_nxt.wstate[i] = stotr_pkg::STOTR_WRITING;
					end else if (!st_r.clr_flag[i] && !any_clr && !clr_granted &&
						clear_start_slot && fast_density_toggle) begin
						// Lowest index wins so two flags never set together
						st_nxt.clr_flag[i] = 1'b1;
						clr_granted = 1'b1;
					end
				end
				stotr_pkg::STOTR_WRITING: begin
					// Write cycle only in the low half of the density toggle
					if (!any_wcyc && write_slot_strobe[i] && !fast_density_toggle) begin
						st_nxt.wcyc[i] = 1'b1;
					end
				end
				default: begin
					st_nxt.wstate[i] = stotr_pkg::STOTR_IDLE;
				end
			endcase
			// Stop ends writing; a running write cycle still completes
			if (reg_wr && reg_addr == `STOTR_OFS_CTRL &&
				reg_wdata[`STOTR_CTRL_STOP_LSB + i] &&
				st_r.wstate[i] == stotr_pkg::STOTR_WRITING) begin
				st_nxt.wstate[i] = stotr_pkg::STOTR_IDLE;
			end
			// Numeric mode takes the next half on each read
			if (buf_read_lo[i] || buf_read_hi[i]) begin
				st_nxt.half[i] = !st_r.alpha[i] && !st_r.half[i];
			end
		end

		// Write cycle length counter, shared because only one cycle runs
		if (any_wcyc) begin
			if (st_r.wcnt == WCYC_LAST) begin
				st_nxt.wcnt = 10'h000;
				st_nxt.wcyc = '0;
			end else begin
				st_nxt.wcnt = st_r.wcnt + 10'h001;
			end
		end

		// High-digit register loads and clears only at even slots
		if (slot_pulse[0] || slot_pulse[2] || slot_pulse[4] || slot_pulse[6]) begin
			st_nxt.high_digit = merged_digit;
		end
		// The staged digit moves down as the high register reloads at T6
		if (slot_pulse[6]) begin
			st_nxt.low_digit = st_r.high_digit;
		end

		// Single-digit flag brackets T5 to T7 of a numeric write cycle
		if (slot_pulse[5] && |(st_r.wcyc & ~st_r.alpha)) begin
			st_nxt.single = 1'b1;
		end else if (slot_pulse[7]) begin
			st_nxt.single = 1'b0;
		end

		// Translate and check at T7 into the write-output flops
		if (slot_pulse[7] && any_wcyc) begin
			st_nxt.char_out = xlate_char;
			st_nxt.char_strobe = 1'b1;
			st_nxt.sync_sel = st_r.wcyc;
			st_nxt.err_pend = check_bad;
			st_nxt.err_sync = st_r.wcyc;
		end

		// Errors surface at T0 and jam the character to all ones
		if (slot_pulse[0] && st_r.err_pend) begin
			st_nxt.err_pend = 1'b0;
			st_nxt.diag_err = 1'b1;
			st_nxt.sync_err = 1'b1;
			st_nxt.merr_set = st_r.err_sync;
			st_nxt.char_out = `STOTR_CHAR_JAM;
			st_nxt.char_strobe = 1'b1;
			st_nxt.sync_sel = st_r.err_sync;
		end

		// Sticky errors: a new error beats a clear in the same cycle
		st_nxt.merr = (st_r.merr & ~merr_clear) | st_nxt.merr_set;

		// Register reads, data appear in the following cycle
		if (reg_rd) begin
			case (reg_addr)
				`STOTR_OFS_CTRL: begin
					st_nxt.rdata[`STOTR_CTRL_ALPHA_LSB +: NSYNC] = st_r.alpha;
				end
				`STOTR_OFS_STAT: begin
					for (int i = 0; i < NSYNC; i++) begin
						st_nxt.rdata[`STOTR_STAT_WRITING_LSB + i] =
							st_r.wstate[i] == stotr_pkg::STOTR_WRITING;
					end
					st_nxt.rdata[`STOTR_STAT_CLEAR_LSB +: NSYNC] = st_r.clr_flag;
					st_nxt.rdata[`STOTR_STAT_WCYC_LSB +: NSYNC] = st_r.wcyc;
					st_nxt.rdata[`STOTR_STAT_MERR_LSB +: NSYNC] = st_r.merr;
				end
				`STOTR_OFS_CHAR: begin
					st_nxt.rdata[6:0] = st_r.char_out;
					st_nxt.rdata[8 +: NSYNC] = st_r.sync_sel;
				end
				default: begin
					st_nxt.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			st_r <= '0;
			for (int i = 0; i < NSYNC; i++) begin
				st_r.wstate[i] <= stotr_pkg::STOTR_IDLE;
			end
			st_r.char_out <= `STOTR_RST_CHAR;
			st_r.high_digit <= `STOTR_RST_DIGIT;
			st_r.low_digit <= `STOTR_RST_DIGIT;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from state
	assign reg_rdata = st_r.rdata;
	assign tape_char = st_r.char_out;
	assign tape_char_strobe = st_r.char_strobe;
	assign tape_sync_sel = st_r.sync_sel;
	assign output_check_diag_error = st_r.diag_err;
	assign output_check_sync_error = st_r.sync_err;
	assign sync_master_error_set = st_r.merr_set;

endmodule

// file: logic/stotr_defines.svh
`ifndef STOTR_DEFINES_SVH
`define STOTR_DEFINES_SVH

// Register byte offsets
`define STOTR_OFS_CTRL 4'h0
`define STOTR_OFS_STAT 4'h4
`define STOTR_OFS_ERRCLR 4'h8
`define STOTR_OFS_CHAR 4'hc

// Control register fields
`define STOTR_CTRL_START_LSB 0
`define STOTR_CTRL_ALPHA_LSB 4
`define STOTR_CTRL_STOP_LSB 8

// Status register fields
`define STOTR_STAT_WRITING_LSB 0
`define STOTR_STAT_CLEAR_LSB 4
`define STOTR_STAT_WCYC_LSB 8
`define STOTR_STAT_MERR_LSB 12

// Reset values
`define STOTR_RST_CHAR 7'h00
`define STOTR_RST_DIGIT 5'h00

// Write cycle length
`define STOTR_CLK_NS 4
`define STOTR_WCYC_NS 4000
`define STOTR_WCYC_CYC (`STOTR_WCYC_NS / `STOTR_CLK_NS)

// One-digit non-numeric codes in standard digit code
`define STOTR_CODE_PLUS 5'h11
`define STOTR_CODE_MINUS 5'h1a
`define STOTR_CODE_SPACE 5'h1b
`define STOTR_CODE_PERIOD 5'h1c
`define STOTR_CODE_IGNORE 5'h1d

// All-ones character forced after a check failure
`define STOTR_CHAR_JAM 7'h7f

`endif

// file: logic/stotr_pkg.sv
package stotr_pkg;

	// Per-synchronizer write operation progress
	typedef enum logic [2:0] {
		STOTR_IDLE = 3'b001,
		STOTR_CLEARING = 3'b010,
		STOTR_WRITING = 3'b100
	} stotr_wstate_type;

	// Decoder outputs feeding the encoder matrix
	typedef struct packed {
		logic [7:0] low_line;      // 08,19,2,3,4,5,6,7
		logic [4:0] sym_line;      // Plus, minus, space, period, ignore
		logic [7:0] range_line;    // 1024,2534,3544,...,8594
		logic lower_range_line_all;
		logic lower_range_line_no_plus;
		logic upper_range_line_all;
		logic upper_range_line_no_ignore_period;
	} stotr_lines_type;

	// Encoder result: six code bits plus four check terms
	typedef struct packed {
		logic [5:0] bits;          // Zone 6..5, value 4..1
		logic [3:0] check_term;    // Terms 4..1
	} stotr_enc_type;

endpackage

// file: logic/stotr_decoder.sv
`timescale 1ns/1ns
`include "stotr_defines.svh"

// Decodes low digit, high digit and single-digit flag into lines
module stotr_decoder (
	input wire logic [4:0] low_digit,
	input wire logic [4:0] high_digit,
	input wire logic single_digit,
	output stotr_pkg::stotr_lines_type lines
);

	logic [6:0] code_value; // Two-digit code as a number
	logic low_bit4;         // Fourth binary bit of the low digit
	logic is_sym;           // Low digit is a non-numeric one-digit code

	assign low_bit4 = low_digit[3];
	assign code_value = 7'(high_digit[3:0]) * 7'h0a + 7'(low_digit[3:0]);
	assign is_sym = low_digit[4];

	// Low digit lines; 0/8 and 1/9 share a line because they share value bits
	assign lines.low_line[0] = !is_sym && (low_digit[3:0] == 4'h0 || low_digit[3:0] == 4'h8);
	assign lines.low_line[1] = !is_sym && (low_digit[3:0] == 4'h1 || low_digit[3:0] == 4'h9);
	genvar g;
	generate
		for (g = 2; g < 8; g = g + 1) begin : g_low
			assign lines.low_line[g] = !is_sym && (low_digit[3:0] == 4'(g));
		end
	endgenerate

	// Symbol lines are gated off outside one-digit translation
	assign lines.sym_line[0] = single_digit && low_digit == `STOTR_CODE_PLUS;
	assign lines.sym_line[1] = single_digit && low_digit == `STOTR_CODE_MINUS;
	assign lines.sym_line[2] = single_digit && low_digit == `STOTR_CODE_SPACE;
	assign lines.sym_line[3] = single_digit && low_digit == `STOTR_CODE_PERIOD;
	assign lines.sym_line[4] = single_digit && low_digit == `STOTR_CODE_IGNORE;

	// Two-digit range lines, each a span of ten codes (first one fifteen)
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_range
			localparam logic [6:0] LO = (g == 0) ? 7'h0a : 7'(15 + 10 * g);
			localparam logic [6:0] HI = 7'(24 + 10 * g);
			assign lines.range_line[g] = !single_digit && code_value >= LO &&
				code_value <= HI;
		end
	endgenerate

	// One-digit range lines use the fourth bit, less plus or ignore/period; high register is empty
	assign lines.lower_range_line_all = single_digit && !low_bit4;
	assign lines.lower_range_line_no_plus = single_digit && !low_bit4 &&
		low_digit != `STOTR_CODE_PLUS;
	assign lines.upper_range_line_all = single_digit && low_bit4;
	assign lines.upper_range_line_no_ignore_period = single_digit && low_bit4 &&
		low_digit != `STOTR_CODE_IGNORE && low_digit != `STOTR_CODE_PERIOD;

endmodule

// file: logic/stotr_encoder.sv
`timescale 1ns/1ns
`include "stotr_defines.svh"

// Encoder matrix plus an independently built inverse for checking
module stotr_encoder #(
	// Value bits 3..1 per low line; the code table is supplied here
	parameter logic [23:0] LOW_BITS = 24'h7d6a3c,
	// Value bits 3..1 per symbol line
	parameter logic [14:0] SYM_BITS = 15'h0000,
	// Zone bit 6 per symbol line
	parameter logic [4:0] SYM_Z6 = 5'h04,
	// Zone bit 5 per symbol line
	parameter logic [4:0] SYM_Z5 = 5'h14
) (
	input stotr_pkg::stotr_lines_type lines,
	output stotr_pkg::stotr_enc_type enc,
	output stotr_pkg::stotr_enc_type enc_inv
);

	logic [7:0] r;  // Range lines shorthand
	logic [4:0] s;  // Symbol lines shorthand
	logic lo_ck1;   // Low digit 0,8,2,3,5
	logic lo_ck3;   // Low digit 1,9,4,6,7

	assign r = lines.range_line;
	assign s = lines.sym_line;
	assign lo_ck1 = lines.low_line[0] | lines.low_line[2] | lines.low_line[3] |
		lines.low_line[5];
	assign lo_ck3 = lines.low_line[1] | lines.low_line[4] | lines.low_line[6] |
		lines.low_line[7];

	// Value bits 1..3 from the line tables, true and complement sets
	genvar b;
	generate
		for (b = 0; b < 3; b = b + 1) begin : g_val
			logic [7:0] low_set;
			logic [4:0] sym_set;
			for (genvar i = 0; i < 8; i = i + 1) begin : g_l
				assign low_set[i] = LOW_BITS[3 * i + b];
			end
			for (genvar i = 0; i < 5; i = i + 1) begin : g_s
				assign sym_set[i] = SYM_BITS[3 * i + b];
			end
			assign enc.bits[b] = |(lines.low_line & low_set) | |(s & sym_set);
			assign enc_inv.bits[b] = |(lines.low_line & ~low_set) | |(s & ~sym_set);
		end
	endgenerate

	// Value bit 4 from the upper half ranges
	assign enc.bits[3] = r[1] | r[3] | r[5] | r[7] | lines.upper_range_line_all;
	assign enc_inv.bits[3] = r[0] | r[2] | r[4] | r[6] | lines.lower_range_line_no_plus |
		s[0];

	// Zone bits
	assign enc.bits[4] = r[2] | r[3] | r[6] | r[7] | |(s & SYM_Z5);
	assign enc_inv.bits[4] = r[0] | r[1] | r[4] | r[5] | |(s & ~SYM_Z5) |
		(|lines.low_line & (lines.lower_range_line_all | lines.upper_range_line_all));
	assign enc.bits[5] = r[4] | r[5] | r[6] | r[7] | |(s & SYM_Z6);
	assign enc_inv.bits[5] = r[0] | r[1] | r[2] | r[3] | |(s & ~SYM_Z6) |
		(|lines.low_line & (lines.lower_range_line_all | lines.upper_range_line_all));

	// Check terms; the translator pairs 1 with 2 and 3 with 4
	assign enc.check_term[1] = r[0] | r[3] | r[5] | r[6] | lines.lower_range_line_all;
	assign enc.check_term[0] = lo_ck1 | s[0];
	assign enc.check_term[3] = r[1] | r[2] | r[4] | r[7] | lines.upper_range_line_all;
	assign enc.check_term[2] = lo_ck3 | s[1] | s[2] | s[3] | s[4];
	// Inverses: term 3 mirrors term 1, term 4 mirrors term 2
	assign enc_inv.check_term[1] = r[1] | r[2] | r[4] | r[7] |
		lines.upper_range_line_no_ignore_period | s[3] | s[4];
	assign enc_inv.check_term[0] = lo_ck3 | s[1] | s[2] | s[3] | s[4];
	assign enc_inv.check_term[3] = r[0] | r[3] | r[5] | r[6] |
		lines.lower_range_line_no_plus | s[0];
	assign enc_inv.check_term[2] = lo_ck1 | s[0];

endmodule

// file: sim/stotr_translator_properties.sv
`timescale 1ns/1ns
// Timing checks on the clear, read and output ports of the shared translator
module stotr_translator_properties #(
	parameter int NSYNC = 4
) (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic [7:0] slot_pulse,
	input wire logic [5:0] ring_phase_pulse,
	input wire logic [NSYNC-1:0] buf_read_lo,
	input wire logic [NSYNC-1:0] buf_read_hi,
	input wire logic [NSYNC-1:0] buf_clear,
	input wire logic [6:0] tape_char,
	input wire logic tape_char_strobe,
	input wire logic [NSYNC-1:0] tape_sync_sel,
	input wire logic output_check_diag_error,
	input wire logic output_check_sync_error,
	input wire logic [NSYNC-1:0] sync_master_error_set
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);
	// Interlock keeps the ring phase drive down to one register set
	property p_clr_onehot;
		$onehot0(buf_clear);
	endproperty
	a_clr_onehot: assert property (p_clr_onehot) else $error("two buffer clears at once");
	// Phase 2 never clears
	property p_clr_phase;
		|buf_clear |-> |(ring_phase_pulse & 6'h3b);
	endproperty
	a_clr_phase: assert property (p_clr_phase) else $error("clear outside its ring phases");
	// A synchronizer never clears and reads in the same cycle
	property p_clr_read;
		(buf_clear & (buf_read_lo | buf_read_hi)) == '0;
	endproperty
	a_clr_read: assert property (p_clr_read) else $error("clear overlaps a read");
	property p_rd_lo;
		|buf_read_lo |-> slot_pulse[4];
	endproperty
	a_rd_lo: assert property (p_rd_lo) else $error("low read away from slot four");
	// Numeric mode may read the high half at slot four too
	property p_rd_hi;
		|buf_read_hi |-> slot_pulse[6] || slot_pulse[4];
	endproperty
	a_rd_hi: assert property (p_rd_hi) else $error("high read at a wrong slot");
	// The ORed bus carries one digit at a time
	property p_rd_one;
		$onehot0({buf_read_lo, buf_read_hi});
	endproperty
	a_rd_one: assert property (p_rd_one) else $error("two digits on the bus");
	property p_char_t7;
		tape_char_strobe |-> $past(slot_pulse[7]) || $past(slot_pulse[0]);
	endproperty
	a_char_t7: assert property (p_char_t7) else $error("character outside translate slot");
	property p_sel;
		tape_char_strobe |-> $onehot(tape_sync_sel);
	endproperty
	a_sel: assert property (p_sel) else $error("character owner not one-hot");
	property p_jam;
		output_check_sync_error |-> output_check_diag_error && tape_char_strobe
			&& tape_char == 7'h7f && $past(slot_pulse[0]);
	endproperty
	a_jam: assert property (p_jam) else $error("check error without all-ones");
	property p_merr;
		|sync_master_error_set |-> output_check_sync_error
			&& sync_master_error_set == tape_sync_sel;
	endproperty
	a_merr: assert property (p_merr) else $error("master error on a wrong owner");
	c_char: cover property (tape_char_strobe);
	c_clear: cover property (|buf_clear);
	c_hi: cover property (|buf_read_hi);
endmodule

bind stotr_translator stotr_translator_properties #(.NSYNC(NSYNC)) u_props (
	.mclk(mclk),
	.sys_rst(sys_rst),
	.slot_pulse(slot_pulse),
	.ring_phase_pulse(ring_phase_pulse),
	.buf_read_lo(buf_read_lo),
	.buf_read_hi(buf_read_hi),
	.buf_clear(buf_clear),
	.tape_char(tape_char),
	.tape_char_strobe(tape_char_strobe),
	.tape_sync_sel(tape_sync_sel),
	.output_check_diag_error(output_check_diag_error),
	.output_check_sync_error(output_check_sync_error),
	.sync_master_error_set(sync_master_error_set)
);

// file: sim/stotr_buf_model.sv
`timescale 1ns/1ns
// Output buffer registers of the synchronizers, two halves each
module stotr_buf_model #(
	parameter int NSYNC = 4
) (
	input wire logic mclk,
	input wire logic ld_en,
	input wire logic [1:0] ld_idx,
	input wire logic [4:0] ld_lo,
	input wire logic [4:0] ld_hi,
	input wire logic [NSYNC-1:0] buf_read_lo,
	input wire logic [NSYNC-1:0] buf_read_hi,
	input wire logic [NSYNC-1:0] buf_clear,
	output logic [NSYNC-1:0][1:0][4:0] buf_digit
);
	logic [NSYNC-1:0][1:0][4:0] mem; // Held digits
	// Clear wins over a load so stale digits never survive
	always @(posedge mclk) begin
		for (int n = 0; n < NSYNC; n++) begin
			if (buf_clear[n]) begin
				mem[n] <= '0;
			end else if (ld_en && ld_idx == 2'(n)) begin
				mem[n] <= {ld_hi, ld_lo};
			end
		end
	end
	// Unread halves idle low, as the ORed bus expects
	always_comb begin
		for (int n = 0; n < NSYNC; n++) begin
			buf_digit[n][0] = buf_read_lo[n] ? mem[n][0] : 5'h00;
			buf_digit[n][1] = buf_read_hi[n] ? mem[n][1] : 5'h00;
		end
	end
endmodule

// file: sim/test_shared_tape_output_translator.sv
`timescale 1ns/1ns
`include "stotr_defines.svh"

module test_shared_tape_output_translator;
	logic mclk, sys_rst, reg_wr, reg_rd, clear_start_slot, fast_density_toggle;
	logic [3:0] reg_addr, write_slot_strobe, buf_read_lo, buf_read_hi, buf_clear, tape_sync_sel;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [7:0] slot_pulse;
	logic [5:0] ring_phase_pulse;
	logic [3:0][1:0][4:0] buf_digit;
	logic [6:0] tape_char, last_char;
	logic tape_char_strobe, diag_err, sync_err, ld_en;
	logic [3:0] merr_set, clr_seen;
	logic [1:0] ld_idx;
	logic [4:0] ld_lo, ld_hi;
	logic [6:0] fc; // Frame counter: slots, density half, strobes
	int err_count, checks_done, cyc, errs;
	int cnt [4];

	// Fifteen cycles from T1 hold two whole T4..T7 frames, so no partial frame is translated
	stotr_translator #(.NSYNC(4), .WCYC_CYC(15)) u_dut (
		.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slot_pulse(slot_pulse),
		.ring_phase_pulse(ring_phase_pulse), .clear_start_slot(clear_start_slot),
		.fast_density_toggle(fast_density_toggle), .write_slot_strobe(write_slot_strobe),
		.buf_digit(buf_digit), .buf_read_lo(buf_read_lo), .buf_read_hi(buf_read_hi),
		.buf_clear(buf_clear), .tape_char(tape_char), .tape_char_strobe(tape_char_strobe),
		.tape_sync_sel(tape_sync_sel), .output_check_diag_error(diag_err),
		.output_check_sync_error(sync_err), .sync_master_error_set(merr_set));

	stotr_buf_model #(.NSYNC(4)) u_bufs (
		.mclk(mclk), .ld_en(ld_en), .ld_idx(ld_idx), .ld_lo(ld_lo), .ld_hi(ld_hi),
		.buf_read_lo(buf_read_lo), .buf_read_hi(buf_read_hi), .buf_clear(buf_clear),
		.buf_digit(buf_digit));

	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	// Timing generator; strobes sit on T0, 16 cycles apart, so write cycles never meet
	always @(posedge mclk) begin
		logic [7:0] sp;
		sp = 8'h01 << fc[2:0];
		fc <= sys_rst ? 7'h00 : fc + 7'h01;
		slot_pulse <= sp;
		ring_phase_pulse <= sp[5:0] | {4'h0, sp[7:6]};
		fast_density_toggle <= fc[6];
		clear_start_slot <= (fc == 7'h60);
		for (int n = 0; n < 4; n++) write_slot_strobe[n] <= (fc == 7'(16 * n));
	end

	// Monitor of produced characters, clears and hangs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		clr_seen <= clr_seen | buf_clear;
		if (sync_err) errs <= errs + 1;
		if (tape_char_strobe) begin
			last_char <= tape_char;
			for (int n = 0; n < 4; n++) if (tape_sync_sel[n]) cnt[n] <= cnt[n] + 1;
		end
		if (cyc == 30000) begin
			err_count++;
			wrap_up();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Poll status until the masked field settles, bounded
	task automatic wait_stat(input logic [31:0] m, input logic [31:0] want);
		for (int i = 0; i < 500; i++) begin
			rd(`STOTR_OFS_STAT);
			if ((v & m) === want) break;
		end
		chk(v & m, want);
	endtask

	task automatic load(input logic [1:0] idx, input logic [4:0] lo, input logic [4:0] hi);
		@(posedge mclk);
		ld_en <= 1'b1;
		ld_idx <= idx;
		ld_lo <= lo;
		ld_hi <= hi;
		@(posedge mclk);
		ld_en <= 1'b0;
	endtask

	// A fresh character must reach the tape bus for this owner
	task automatic wait_char(input int n);
		int c0;
		c0 = cnt[n];
		for (int i = 0; i < 2000 && cnt[n] == c0; i++) @(posedge mclk);
		chk(32'(cnt[n] != c0), 32'h1);
	endtask

	task automatic wrap_up();
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		{reg_wr, reg_rd, ld_en, ld_idx, ld_lo, ld_hi, reg_addr, reg_wdata} = '0;
		{slot_pulse, ring_phase_pulse, clear_start_slot, fast_density_toggle} = '0;
		{write_slot_strobe, fc, clr_seen, last_char} = '0;
		{cyc, errs, err_count, checks_done} = '0;
		cnt = '{0, 0, 0, 0};
		sys_rst = 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		// Reset state, unmapped place ignored
		rd(`STOTR_OFS_STAT);
		chk(v, 32'h0);
		rd(`STOTR_OFS_CHAR);
		chk(v, 32'h0);
		wr(4'h1, 32'hffff_ffff);
		rd(4'h1);
		chk(v, 32'h0);
		rd(`STOTR_OFS_CTRL);
		chk(v, 32'h0);
		$display("test reset done");
		// Numeric write on synchronizer 0
		wr(`STOTR_OFS_CTRL, 32'h1);
		wait_stat(32'h1, 32'h1);
		chk(32'(clr_seen[0]), 32'h1);
		load(2'h0, 5'h05, 5'h07);
		wait_char(0);
		chk(32'(last_char == `STOTR_CHAR_JAM), 32'h0);
		rd(`STOTR_OFS_CHAR);
		chk(32'(v[11:8]), 32'h1);
		$display("test numeric done");
		// Two alpha writers and a numeric symbol writer share the translator
		// Each buffer is filled as soon as its clear is over, before its first write cycle
		wr(`STOTR_OFS_CTRL, 32'h6e);
		wait_stat(32'h2, 32'h2);
		load(2'h1, 5'h05, 5'h03);
		wait_stat(32'h4, 32'h4);
		load(2'h2, 5'h04, 5'h04);
		wait_stat(32'h8, 32'h8);
		load(2'h3, `STOTR_CODE_MINUS, 5'h00);
		chk(32'(clr_seen), 32'hf);
		rd(`STOTR_OFS_CTRL);
		chk(v, 32'h60);
		wait_char(1);
		wait_char(2);
		wait_char(3);
		chk(32'(errs), 32'h0);
		$display("test shared done");
		// Stop all writers and clear master errors
		wr(`STOTR_OFS_CTRL, 32'hf00);
		wait_stat(32'hf, 32'h0);
		wr(`STOTR_OFS_ERRCLR, 32'hf000);
		rd(`STOTR_OFS_STAT);
		chk(32'(v[15:12]), 32'h0);
		$display("test stop done");
		wrap_up();
	end
endmodule
